/* rtl/dpd_diag_top.sv */
// device-specific diagnostic builder with Avalon-MM register access
// assumes one clock, synchronous inputs, master reads section on request
//
// What this block does
// - section is always ten bytes; length 001010 in bits 0..5 of byte 0
// - bits 6..7 of byte 0 hold fixed code 00
// - configuration faults reported as codes 12h..17h in message byte
// - no fault and payload released: message byte reads 40h
// - last five section bytes mirror the latest written user payload
// - six-byte block: status byte then five payload bytes
// - diagnostic starts only on a 0 to 1 change of status
// - status value 03h starts and deletes nothing, but is still stored
// - status bit 0 is payload validity; 1 starts a diagnostic
// - status bit 1 requests deletion; bits 2..7 reserved
// - section returned on master request and flagged on errors
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module dpd_diag_top
   import dpd_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // avalon-mm slave
   input  dpd_pkg::dpd_avm_req_s avm_req,
   output dpd_pkg::dpd_avm_rsp_s avm_rsp,
   // fault detection from protocol side
   input  wire logic         fault_valid,
   input  wire logic [7:0]   fault_code,
   // diagnostic request from master side
   input  wire logic         diag_req,
   // diagnostic toward master
   output logic              diag_notify,
   output logic              sect_valid,
   output dpd_pkg::dpd_sect_t sect,
   // interrupt
   output logic              irq
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]  status_r;
   logic [39:0] payload_r;
   logic [7:0]  fault_r;
   logic        released_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_en_r;
   logic [7:0]  msg_r;
   logic [7:0]  msg_nxt;
   logic        rd_pend_r;
   logic [31:0] rdata_r;
   logic        notify_r;
   logic        sect_valid_r;
   logic        diag_start;
   logic        diag_delete;
   logic        stat_wr;
   logic        wr_acc;
   logic        fault_ev;
   logic [2:0]  ev_vec;
   // one write cycle is accepted at once; reads take one wait cycle
   assign wr_acc  = avm_req.write;
   assign stat_wr = wr_acc && (avm_req.address == DPD_OFS_STATUS)
                    && avm_req.byteenable[0];
   // one driver for the whole response word
   assign avm_rsp = '{readdata: rdata_r, waitrequest: avm_req.read && !rd_pend_r};
   // ---------------------------------------------------------------
   // edge detection on status writes
   // ---------------------------------------------------------------
   dpd_edge_detect u_edge (
      .clk         (clk),
      .reset_n     (reset_n),
      .sample      (stat_wr),
      .status      (avm_req.writedata[7:0]),
      .diag_start  (diag_start),
      .diag_delete (diag_delete)
   );
   // ---------------------------------------------------------------
   // status byte and payload block
   // ---------------------------------------------------------------
   // status written every update; bits 2..7 stored but carry no meaning
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= DPD_RST_BYTE;
      end else if (stat_wr) begin
         status_r <= avm_req.writedata[7:0];
      end
   end
   // payload bytes 1..5 of the block, byte enables honoured
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         payload_r <= '0;
      end else if (wr_acc && avm_req.address == DPD_OFS_PAYLO) begin
         for (int i = 0; i < 4; i++) begin
            if (avm_req.byteenable[i]) begin
               payload_r[39-8*i -: 8] <= avm_req.writedata[8*i +: 8];
            end
         end
      end else if (wr_acc && avm_req.address == DPD_OFS_PAYHI
                   && avm_req.byteenable[0]) begin
         payload_r[7:0] <= avm_req.writedata[7:0];
      end
   end
   // ---------------------------------------------------------------
   // release and fault state
   // ---------------------------------------------------------------
   // release follows the valid edge; delete withdraws it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         released_r <= 1'b0;
      end else if (diag_start) begin
         released_r <= 1'b1;
      end else if (diag_delete) begin
         released_r <= 1'b0;
      end
   end
   // only codes in range are latched; others would be meaningless
   assign fault_ev = fault_valid && dpd_is_fault(fault_code);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_r <= DPD_MSG_NONE;
      end else if (fault_ev) begin
         fault_r <= fault_code;
      end else if (wr_acc && avm_req.address == DPD_OFS_FAULT) begin
         fault_r <= DPD_MSG_NONE;
      end
   end
   // fault wins over the valid mark
   always_comb begin
      if (fault_r != DPD_MSG_NONE) begin
         msg_nxt = fault_r;
      end else if (released_r) begin
         msg_nxt = DPD_MSG_VALID;
      end else begin
         msg_nxt = DPD_MSG_NONE;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msg_r <= DPD_MSG_NONE;
      end else begin
         msg_r <= msg_nxt;
      end
   end
   // ---------------------------------------------------------------
   // section assembly
   // ---------------------------------------------------------------
   dpd_sect_builder #(
      .USER_BYTES (DPD_USER_BYTES)
   ) u_build (
      .clk     (clk),
      .reset_n (reset_n),
      .msg     (msg_r),
      .payload (payload_r),
      .sect_r  (sect)
   );
   // ---------------------------------------------------------------
   // toward the master
   // ---------------------------------------------------------------
   // unsolicited notify on start or fault; delayed two cycles so it rises
   // with the new message byte in msg_r, one cycle before the section image holds it
   logic notify_d_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         notify_d_r <= 1'b0;
         notify_r   <= 1'b0;
      end else begin
         notify_d_r <= diag_start || fault_ev;
         notify_r   <= notify_d_r;
      end
   end
   assign diag_notify = notify_r;
   // answer to a master request one cycle later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sect_valid_r <= 1'b0;
      end else begin
         sect_valid_r <= diag_req;
      end
   end
   assign sect_valid = sect_valid_r;
   // ---------------------------------------------------------------
   // interrupt status, enable, clear
   // ---------------------------------------------------------------
   assign ev_vec = {fault_ev, diag_delete, diag_start};
   // a new event in the clear cycle is kept: set wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_acc && avm_req.address == DPD_OFS_IRQ_CLR)
                       ? avm_req.writedata[2:0] : 3'h0)) | ev_vec;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_en_r <= '0;
      end else if (wr_acc && avm_req.address == DPD_OFS_IRQ_EN) begin
         irq_en_r <= avm_req.writedata[2:0];
      end
   end
   assign irq = |(irq_stat_r & irq_en_r);
   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // read data registered; answer comes one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend_r <= 1'b0;
         rdata_r   <= '0;
      end else begin
         rd_pend_r <= avm_req.read && !rd_pend_r;
         if (avm_req.read && !rd_pend_r) begin
            unique case (avm_req.address)
               DPD_OFS_STATUS:   rdata_r <= {24'h0, status_r};
               DPD_OFS_PAYLO:    rdata_r <= {payload_r[7+8:8], payload_r[23:16],
                                             payload_r[31:24], payload_r[39:32]};
               DPD_OFS_PAYHI:    rdata_r <= {24'h0, payload_r[7:0]};
               DPD_OFS_FAULT:    rdata_r <= {24'h0, fault_r};
               DPD_OFS_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
               DPD_OFS_IRQ_EN:   rdata_r <= {29'h0, irq_en_r};
               DPD_OFS_IRQ_CLR:  rdata_r <= 32'h0;
               DPD_OFS_MSG:      rdata_r <= {24'h0, msg_r};
               default:          rdata_r <= DPD_UNMAPPED;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   valid_msg_a: assert property (@(posedge clk) disable iff (!reset_n)
      (released_r && fault_r == DPD_MSG_NONE) |=> msg_r == 8'h40)
      else $error("valid mark missing");
   fault_msg_a: assert property (@(posedge clk) disable iff (!reset_n)
      fault_ev |=> fault_r == $past(fault_code) ##1 msg_r == fault_r)
      else $error("fault code not reported");
   start_release_a: assert property (@(posedge clk) disable iff (!reset_n)
      diag_start |=> released_r)
      else $error("start did not release payload");
   notify_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
      diag_start |-> ##2 diag_notify)
      else $error("notify not raised two cycles after start");
   payload_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n |=> sect[39:0] == $past(payload_r))
      else $error("payload not mirrored");
   delete_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (diag_delete && !diag_start) |=> !released_r)
      else $error("delete did not clear release");
   request_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
      diag_req |=> sect_valid)
      else $error("request not answered");
   status_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
      stat_wr |=> status_r == $past(avm_req.writedata[7:0]))
      else $error("status byte not stored");
   cov_start_c:  cover property (@(posedge clk) disable iff (!reset_n) diag_start);
   cov_delete_c: cover property (@(posedge clk) disable iff (!reset_n) diag_delete);
   cov_fault_c:  cover property (@(posedge clk) disable iff (!reset_n) fault_ev);
   cov_irq_c:    cover property (@(posedge clk) disable iff (!reset_n) irq);
endmodule

/* rtl/dpd_pkg.sv */
// package for the device-specific diagnostic builder
// assumes a single 100 MHz clock domain and an Avalon-MM register bus
package dpd_pkg;
   // ---------------------------------------------------------------
   // section layout
   // ---------------------------------------------------------------
   localparam int            DPD_SECT_BYTES   = 10;
   localparam int            DPD_USER_BYTES   = 5;
   localparam logic [5:0]    DPD_LEN_FIELD    = 6'h0A;
   localparam logic [1:0]    DPD_CODE_FIELD   = 2'h0;
   localparam logic [7:0]    DPD_MSG_NONE     = 8'h00;
   localparam logic [7:0]    DPD_MSG_VALID    = 8'h40;
   localparam logic [7:0]    DPD_FAULT_FIRST  = 8'h12;
   localparam logic [7:0]    DPD_FAULT_LAST   = 8'h17;
   localparam logic [7:0]    DPD_STAT_IGNORE  = 8'h03;
   localparam int            DPD_STAT_VALID_B = 0;
   localparam int            DPD_STAT_DEL_B   = 1;
   // ---------------------------------------------------------------
   // register word offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [4:0]    DPD_OFS_STATUS   = 5'h00;
   localparam logic [4:0]    DPD_OFS_PAYLO    = 5'h04;
   localparam logic [4:0]    DPD_OFS_PAYHI    = 5'h08;
   localparam logic [4:0]    DPD_OFS_FAULT    = 5'h0C;
   localparam logic [4:0]    DPD_OFS_IRQ_STAT = 5'h10;
   localparam logic [4:0]    DPD_OFS_IRQ_EN   = 5'h14;
   localparam logic [4:0]    DPD_OFS_IRQ_CLR  = 5'h18;
   localparam logic [4:0]    DPD_OFS_MSG      = 5'h1C;
   localparam logic [31:0]   DPD_UNMAPPED     = 32'hDEADBEEF;
   localparam logic [7:0]    DPD_RST_BYTE     = 8'h00;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } dpd_avm_req_s;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } dpd_avm_rsp_s;
   typedef enum logic [1:0] {DPD_EV_DIAG, DPD_EV_DEL, DPD_EV_FAULT} dpd_ev_e;
   // the section is ten bytes, byte 0 first
   typedef logic [DPD_SECT_BYTES*8-1:0] dpd_sect_t;
   // fault code in range check, used by the top only
   function automatic logic dpd_is_fault(input logic [7:0] c);
      return (c >= DPD_FAULT_FIRST) && (c <= DPD_FAULT_LAST);
   endfunction
endpackage

/* rtl/dpd_edge_detect.sv */
// rising edge detector for the diagnostic status byte
// assumes status is written synchronously on clk by the register file
`timescale 1ns/1ps
module dpd_edge_detect
   import dpd_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // sampled status
   input  wire logic       sample,
   input  wire logic [7:0] status,
   // one-cycle events
   output logic            diag_start,
   output logic            diag_delete
);
   logic [7:0] prev_r;
   // ---------------------------------------------------------------
   // previous value of the status byte
   // ---------------------------------------------------------------
   // keep the last sampled value so a transition counts only once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_r <= DPD_RST_BYTE;
      end else if (sample) begin
         prev_r <= status;
      end
   end
   logic ignored;
   assign ignored = (status == DPD_STAT_IGNORE);
   // valid bit 0->1 starts a diagnostic; delete bit 0->1 clears it
   assign diag_start  = sample && !ignored && status[DPD_STAT_VALID_B]
                        && !prev_r[DPD_STAT_VALID_B];
   assign diag_delete = sample && !ignored && status[DPD_STAT_DEL_B]
                        && !prev_r[DPD_STAT_DEL_B];
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   ignore_value_a: assert property (@(posedge clk) disable iff (!reset_n)
      (status == DPD_STAT_IGNORE) |-> !diag_start && !diag_delete)
      else $error("status 03 triggered an action");
   level_no_retrig_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sample && $past(sample) && status[0] && $past(status[0]))
      |-> !diag_start)
      else $error("steady valid bit retriggered");
endmodule

/* rtl/dpd_sect_builder.sv */
// assembles the ten-byte device-specific diagnostic section
// assumes message and payload are registered by the caller
`timescale 1ns/1ps
module dpd_sect_builder
   import dpd_pkg::*;
#(
   parameter int USER_BYTES = DPD_USER_BYTES
)(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // content
   input  wire logic [7:0]              msg,
   input  wire logic [USER_BYTES*8-1:0] payload,
   // section out, byte 0 in the top bits
   output dpd_sect_t                    sect_r
);
   // ---------------------------------------------------------------
   // registered section image
   // ---------------------------------------------------------------
   // header is constant; reserved bytes read zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sect_r <= '0;
      end else begin
         sect_r <= {DPD_CODE_FIELD, DPD_LEN_FIELD,
                    msg, 24'h000000, payload};
      end
   end
   // the release edge itself still loads zeros, so look only from the next edge
   header_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n |=> sect_r[79:72] == 8'h0A)
      else $error("section header not 0A");
endmodule

/* verification/dpd_master_model.sv */
// fieldbus master stand-in: polls the diagnostic section, counts notifies
// assumes the slave answers a request with a one-cycle section strobe
`timescale 1ns/1ps
module dpd_master_model
   import dpd_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // command from bench
   input  wire logic         poll,
   input  wire logic [3:0]   poll_gap,
   // slave side
   input  wire logic         diag_notify,
   input  wire logic         sect_valid,
   input  dpd_pkg::dpd_sect_t sect,
   output logic              diag_req,
   // collected results
   output dpd_pkg::dpd_sect_t got_sect,
   output logic [7:0]        n_notify,
   output logic [7:0]        n_sect
);
   logic       armed_r;
   logic [3:0] wait_r;
   // --------------------------------------------------------------
   // request side
   // --------------------------------------------------------------
   // a gap lets the master ask promptly or late
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_r  <= 1'b0;
         wait_r   <= 4'h0;
         diag_req <= 1'b0;
      end else begin
         diag_req <= 1'b0;
         if (poll && !armed_r) begin
            armed_r <= 1'b1;
            wait_r  <= poll_gap;
         end else if (armed_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
         end else if (armed_r) begin
            armed_r  <= 1'b0;
            diag_req <= 1'b1;
         end
      end
   end
   // --------------------------------------------------------------
   // collection side
   // --------------------------------------------------------------
   // section taken only in its strobe cycle, notifies counted
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         got_sect <= '0;
         n_notify <= 8'h00;
         n_sect   <= 8'h00;
      end else begin
         if (sect_valid) begin
            got_sect <= sect;
            n_sect   <= n_sect + 8'h01;
         end
         if (diag_notify)
            n_notify <= n_notify + 8'h01;
      end
   end
endmodule

/* verification/test_dp_slave_device_diag_builder.sv */
// self-checking bench for the diagnostic section builder
// assumes the master model file and the design files are compiled first
`timescale 1ns/1ps
module test_dp_slave_device_diag_builder;
   import dpd_pkg::*;
   logic               clk = 1'b0;
   logic               reset_n, fault_valid, diag_req, diag_notify, sect_valid, irq, poll;
   logic [7:0]         fault_code, n_notify, n_sect, nb;
   logic [3:0]         poll_gap;
   logic [31:0]        rd, plo, phi;
   dpd_avm_req_s       req;
   dpd_avm_rsp_s       rsp;
   dpd_sect_t          sect, got_sect;
   int                 n_fail = 0, checked = 0, cyc = 0;
   // --------------------------------------------------------------
   // clock, instances, timeout
   // --------------------------------------------------------------
   always #5 clk = ~clk;
   dpd_diag_top dut_u (.clk(clk), .reset_n(reset_n), .avm_req(req), .avm_rsp(rsp),
      .fault_valid(fault_valid), .fault_code(fault_code), .diag_req(diag_req),
      .diag_notify(diag_notify), .sect_valid(sect_valid), .sect(sect), .irq(irq));
   dpd_master_model master_u (.clk(clk), .reset_n(reset_n), .poll(poll),
      .poll_gap(poll_gap), .diag_notify(diag_notify), .sect_valid(sect_valid),
      .sect(sect), .diag_req(diag_req), .got_sect(got_sect), .n_notify(n_notify),
      .n_sect(n_sect));
   // a hung handshake must still reach the verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         $display("ERROR t=%0t timeout", $time);
         n_fail++;
         tally_and_finish();
      end
   end
   // --------------------------------------------------------------
   // expectations, checks, bus cycles
   // --------------------------------------------------------------
   function automatic logic [31:0] sb(input dpd_sect_t s, input int k);
      return {24'h0, s[79-8*k -: 8]};
   endfunction
   function automatic logic [31:0] exp_hdr();
      return {24'h0, 2'h0, 6'h0A};
   endfunction
   function automatic logic [31:0] exp_user(input int k);
      return (k < 4) ? {24'h0, plo[8*k +: 8]} : {24'h0, phi[7:0]};
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   // request held until waitrequest is seen low, released after that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      @(posedge clk);
      req.address    <= a;
      req.read       <= !wr;
      req.write      <= wr;
      req.writedata  <= wd;
      req.byteenable <= 4'hF;
      // waitrequest and readdata are looked at on the rising edge itself
      do @(posedge clk); while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      req.read  <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk_word(rd, exp, what);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic fault(input logic [7:0] c);
      @(posedge clk);
      fault_valid <= 1'b1;
      fault_code  <= c;
      @(posedge clk);
      fault_valid <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(11));
      reset_n = 1'b0; fault_valid = 1'b0; fault_code = 8'h00; poll = 1'b0; poll_gap = 4'h0;
      req = '0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      idle(2);
      chk_word(sb(sect, 0), exp_hdr(), "header after reset");
      rd_chk(DPD_OFS_STATUS, 32'h0, "status reset");
      rd_chk(5'h1E, DPD_UNMAPPED, "unmapped read");
      // payload mirror, all-ones corner first
      for (int i = 0; i < 3; i++) begin
         plo = (i == 0) ? 32'hFFFFFFFF : $urandom();
         phi = (i == 0) ? 32'h000000FF : {24'h0, 8'($urandom())};
         bus(1'b1, DPD_OFS_PAYLO, plo);
         bus(1'b1, DPD_OFS_PAYHI, phi);
         rd_chk(DPD_OFS_PAYLO, plo, "payload low");
         idle(3);
         for (int k = 0; k < 5; k++) chk_word(sb(sect, 5 + k), exp_user(k), "user byte");
      end
      $display("test payload done");
      // start on a rising edge only, once
      bus(1'b1, DPD_OFS_IRQ_EN, 32'h7);
      nb = n_notify;
      bus(1'b1, DPD_OFS_STATUS, 32'h1);
      idle(4);
      chk_word({24'h0, n_notify}, {24'h0, nb + 8'h01}, "one notify");
      chk_flag(irq, 1'b1, "irq on start");
      rd_chk(DPD_OFS_MSG, 32'h40, "valid message");
      chk_word(sb(sect, 1), 32'h40, "message in section");
      bus(1'b1, DPD_OFS_STATUS, 32'h1);
      idle(4);
      chk_word({24'h0, n_notify}, {24'h0, nb + 8'h01}, "steady level");
      bus(1'b1, DPD_OFS_IRQ_CLR, 32'h1);
      idle(1);
      chk_flag(irq, 1'b0, "irq cleared");
      $display("test start done");
      // ignored value, reserved bits, delete
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, DPD_OFS_STATUS, 32'h0);
         bus(1'b1, DPD_OFS_STATUS, (j == 0) ? 32'h3 : 32'h4);
         idle(4);
         chk_word({24'h0, n_notify}, {24'h0, nb + 8'h01}, "no action");
         rd_chk(DPD_OFS_IRQ_STAT, 32'h0, "no event");
      end
      bus(1'b1, DPD_OFS_STATUS, 32'h0);
      bus(1'b1, DPD_OFS_STATUS, 32'h2);
      idle(4);
      rd_chk(DPD_OFS_IRQ_STAT, 32'h2, "delete event");
      bus(1'b1, DPD_OFS_IRQ_CLR, 32'h2);
      $display("test status codes done");
      // every fault code wins over the valid message
      bus(1'b1, DPD_OFS_STATUS, 32'h0);
      bus(1'b1, DPD_OFS_STATUS, 32'h1);
      bus(1'b1, DPD_OFS_IRQ_CLR, 32'h7);
      idle(3); // the start notify lands two edges later; count it before the loop
      for (logic [7:0] c = 8'h12; c <= 8'h17; c++) begin
         nb = n_notify;
         fault(c);
         idle(4);
         rd_chk(DPD_OFS_MSG, {24'h0, c}, "fault message");
         chk_word(sb(sect, 1), {24'h0, c}, "fault in section");
         chk_word({24'h0, n_notify}, {24'h0, nb + 8'h01}, "fault notify");
         bus(1'b1, DPD_OFS_IRQ_CLR, 32'h4);
         bus(1'b1, DPD_OFS_FAULT, 32'h0);
      end
      nb = n_notify;
      fault(8'h11);
      fault(8'h18);
      idle(4);
      chk_word({24'h0, n_notify}, {24'h0, nb}, "out of range");
      rd_chk(DPD_OFS_IRQ_STAT, 32'h0, "out of range no event");
      // masked interrupt
      bus(1'b1, DPD_OFS_IRQ_EN, 32'h0);
      fault(8'h15);
      idle(4);
      chk_flag(irq, 1'b0, "irq masked");
      rd_chk(DPD_OFS_IRQ_STAT, 32'h4, "sticky fault bit");
      bus(1'b1, DPD_OFS_IRQ_EN, 32'h4);
      idle(1);
      chk_flag(irq, 1'b1, "irq unmasked");
      bus(1'b1, DPD_OFS_IRQ_CLR, 32'h4);
      bus(1'b1, DPD_OFS_FAULT, 32'h0);
      idle(1);
      chk_flag(irq, 1'b0, "irq after clear");
      $display("test faults done");
      // master polls promptly and late
      bus(1'b1, DPD_OFS_STATUS, 32'h0);
      bus(1'b1, DPD_OFS_STATUS, 32'h1);
      for (int j = 0; j < 2; j++) begin
         nb = n_sect;
         @(posedge clk);
         poll     <= 1'b1;
         poll_gap <= (j == 0) ? 4'h0 : 4'(8 + $urandom_range(7));
         @(posedge clk);
         poll <= 1'b0;
         for (int n = 0; n < 40 && n_sect == nb; n++) @(posedge clk);
         idle(1);
         chk_word({24'h0, n_sect}, {24'h0, nb + 8'h01}, "section answered");
         chk_word(sb(got_sect, 0), exp_hdr(), "polled header");
         chk_word(sb(got_sect, 1), 32'h40, "polled message");
         for (int k = 0; k < 5; k++) begin
            chk_word(sb(got_sect, 5 + k), exp_user(k), "polled user");
         end
      end
      $display("test poll done");
      tally_and_finish();
   end
endmodule
